// *** hw/spi_clkdiv.sv ***
// Purpose: enable pulse every (div+1) cycles
// Assumes: one clock
// Notes: clear restarts the count
`timescale 1ns/100ps
module spi_clkdiv
(
   // clock
   input  wire logic       clk,
   input  wire logic       rst,
   // control
   input  wire logic       run,
   input  wire logic [7:0] div,
   output logic            tick
);
   logic [7:0] cnt_q;
   wire        wrap = (cnt_q == div);
   always_ff @(posedge clk)
   begin
      if (rst || !run)
      begin
         cnt_q <= 8'h00;
         tick  <= 1'b0;
      end
      else
      begin
         cnt_q <= wrap ? 8'h00 : cnt_q + 8'h01;
         tick  <= wrap;
      end
   end
endmodule

// *** hw/spi_ctl.sv ***
// Purpose: serial port with control registers, apb slave, one byte shifter
// Assumes: 50 MHz clk, sync active-high rst, link pins asynchronous
// Notes: half serial clock period is (baud+1) clk cycles in master role
`timescale 1ns/100ps
`include "spi_ctl_consts.svh"
module spi_ctl
(
   // clock and reset
   input  wire logic                  clk,
   input  wire logic                  rst,
   // apb
   input  wire logic                  psel,
   input  wire logic                  penable,
   input  wire logic                  pwrite,
   input  wire logic [11:0]           paddr,
   input  wire logic [31:0]           pwdata,
   output logic      [31:0]           prdata,
   output logic                       pready,
   output logic                       pslverr,
   // system
   input  wire logic                  cpu_wait,
   output logic                       irq,
   // link pins
   input  wire spi_ctl_pkg::pins_in_t pins_in,
   input  wire logic                  miso_i,
   output spi_ctl_pkg::pins_out_t     pins_out,
   output logic                       ss_gpio_free
);
   logic [7:0] ctl1_q, ctl2_q, stat_q, mask_q, baud_q, tx_q, rx_q;
   logic [7:0] sh_q;
   logic [3:0] cnt_q;
   logic       sck_q, ph_q, done_q, modf_q;
   spi_ctl_pkg::xfer_st_t st_q;
   spi_ctl_pkg::pins_out_t po_d;
   logic sck_s, mosi_s, ss_s, miso_s, sck_prev_q;

   spi_sync2 u_sck  (.clk(clk), .rst(rst), .d(pins_in.sck),  .q(sck_s));
   spi_sync2 u_mosi (.clk(clk), .rst(rst), .d(pins_in.mosi), .q(mosi_s));
   spi_sync2 u_ss   (.clk(clk), .rst(rst), .d(pins_in.ss_n), .q(ss_s));
   spi_sync2 u_miso (.clk(clk), .rst(rst), .d(miso_i),       .q(miso_s));

   // configuration decode
   wire en     = ctl1_q[`B_PORTEN];
   wire master = ctl1_q[`B_ROLE];
   wire clock_polarity   = ctl1_q[`B_CLOCK_POLARITY];
   wire clock_phase   = ctl1_q[`B_CLOCK_PHASE];
   wire lsbf   = ctl1_q[`B_LSBF];
   wire fault_en = ctl2_q[`B_FAULT_EN];
   wire sel_oe   = ctl1_q[`B_SEL_OE];
   wire frozen = ctl2_q[`B_SWAI] & cpu_wait;
   wire ss_free  = master & ~fault_en;
   wire ss_sense = en & master & fault_en & ~sel_oe;
   wire ss_drive = en & master & fault_en & sel_oe;

   // apb decode
   wire acc     = psel & penable;
   wire wr      = acc & pwrite;
   wire hit1    = paddr == `OFS_CTL1;
   wire hit2    = paddr == `OFS_CTL2;
   wire hit_st  = paddr == `OFS_STATUS;
   wire hit_mk  = paddr == `OFS_MASK;
   wire hit_dt  = paddr == `OFS_DATA;
   wire hit_bd  = paddr == `OFS_BAUD;
   wire mapped  = hit1 | hit2 | hit_st | hit_mk | hit_dt | hit_bd;
   wire start   = wr & hit_dt & en & master & (st_q == spi_ctl_pkg::ST_IDLE) & ~frozen;
   wire [7:0] rd_mux =
      hit1 ? ctl1_q : hit2 ? ctl2_q : hit_st ? stat_q :
      hit_mk ? mask_q : hit_dt ? rx_q : hit_bd ? baud_q : 8'h00;

   // master timing
   logic tick;
   spi_clkdiv u_div
   (
      .clk  (clk),
      .rst  (rst),
      .run  (en & master & ~frozen & (st_q != spi_ctl_pkg::ST_IDLE)),
      .div  (baud_q),
      .tick (tick)
   );

   // slave edge detect on synchronised clock
   wire s_act  = en & ~master & ~ss_s & ~frozen;
   wire s_rise = s_act & sck_s & ~sck_prev_q;
   wire s_fall = s_act & ~sck_s & sck_prev_q;
   wire s_lead = clock_polarity ? s_fall : s_rise;
   wire s_trail= clock_polarity ? s_rise : s_fall;
   wire s_samp = clock_phase ? s_trail : s_lead;
   logic ss_prev_q;
   wire ss_fall_slave = en & ~master & ~ss_s & ss_prev_q;

   // bit in and shifted word
   wire in_bit = master ? miso_s : mosi_s;
   wire out_bit = lsbf ? sh_q[0] : sh_q[7];
   wire [7:0] sh_in = lsbf ? {in_bit, sh_q[7:1]} : {sh_q[6:0], in_bit};

   // fault detection
   wire fault = ss_sense & ~ss_s;

   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         ctl1_q <= `CTL1_RESET;
         ctl2_q <= `CTL2_RESET;
         mask_q <= 8'h00;
         baud_q <= `BAUD_RESET;
         tx_q   <= 8'h00;
      end
      else if (wr)
      begin
         if (hit1)
            ctl1_q <= fault ? {pwdata[7:5], 1'b0, pwdata[3:0]} : pwdata[7:0];
         else if (fault)
            ctl1_q[`B_ROLE] <= 1'b0;
         if (hit2)
            ctl2_q <= pwdata[7:0] & `CTL2_MASK;
         if (hit_mk)
            mask_q <= pwdata[7:0];
         if (hit_bd)
            baud_q <= pwdata[7:0];
         if (hit_dt)
            tx_q <= pwdata[7:0];
      end
      else if (fault)
         ctl1_q[`B_ROLE] <= 1'b0;
   end

   // sticky status, set wins over write-one clear
   wire [7:0] ev = {6'h00, modf_q, done_q};
   always_ff @(posedge clk)
   begin
      if (rst)
         stat_q <= 8'h00;
      else
         stat_q <= (stat_q & ~((wr & hit_st) ? pwdata[7:0] : 8'h00)) | ev;
   end

   // transfer engine
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         st_q   <= spi_ctl_pkg::ST_IDLE;
         sh_q   <= 8'h00;
         rx_q   <= 8'h00;
         cnt_q  <= 4'h0;
         sck_q  <= 1'b0;
         ph_q   <= 1'b0;
         done_q <= 1'b0;
         modf_q <= 1'b0;
         sck_prev_q <= 1'b0;
         ss_prev_q  <= 1'b1;
      end
      else
      begin
         done_q <= 1'b0;
         modf_q <= fault;
         sck_prev_q <= sck_s;
         ss_prev_q  <= ss_s;
         if (!en || fault || (!master && ss_s))
         begin
            st_q  <= spi_ctl_pkg::ST_IDLE;
            sck_q <= 1'b0;
            cnt_q <= 4'h0;
         end
         else if (!frozen)
         begin
            if (!master)
            begin
               if (ss_fall_slave)
                  sh_q <= tx_q;
               else if (s_samp)
               begin
                  sh_q  <= sh_in;
                  cnt_q <= cnt_q + 4'h1;
                  if (cnt_q == `BITS_PER_XFER - 4'd1)
                  begin
                     rx_q   <= sh_in;
                     done_q <= 1'b1;
                     cnt_q  <= 4'h0;
                  end
               end
            end
            else
            begin
               case (st_q)
                  spi_ctl_pkg::ST_IDLE:
                  begin
                     if (start)
                     begin
                        sh_q  <= pwdata[7:0];
                        cnt_q <= 4'h0;
                        ph_q  <= 1'b0;
                        st_q  <= clock_phase ? spi_ctl_pkg::ST_SHIFT : spi_ctl_pkg::ST_LEAD;
                        sck_q <= clock_phase;
                     end
                  end
                  spi_ctl_pkg::ST_LEAD:
                     if (tick)
                     begin
                        st_q  <= spi_ctl_pkg::ST_SHIFT;
                        sck_q <= 1'b1;
                        ph_q  <= 1'b1;
                     end
                  spi_ctl_pkg::ST_SHIFT:
                     if (tick)
                     begin
                        ph_q <= ~ph_q;
                        if (ph_q)
                        begin
                           sh_q  <= sh_in;
                           cnt_q <= cnt_q + 4'h1;
                           sck_q <= clock_phase ? 1'b1 : 1'b0;
                           if (cnt_q == `BITS_PER_XFER - 4'd1)
                           begin
                              rx_q   <= sh_in;
                              done_q <= 1'b1;
                              st_q   <= spi_ctl_pkg::ST_TAIL;
                              sck_q  <= 1'b0;
                           end
                        end
                        else
                           sck_q <= clock_phase ? 1'b0 : 1'b1;
                     end
                  spi_ctl_pkg::ST_TAIL:
                     if (tick)
                        st_q <= spi_ctl_pkg::ST_IDLE;
                  default:
                     st_q <= spi_ctl_pkg::ST_IDLE;
               endcase
            end
         end
      end
   end

   // pin drive, enables low while driving
   always_comb
   begin
      po_d.sck_o     = sck_q ^ clock_polarity;
      po_d.sck_oe_n  = ~(en & master);
      po_d.mosi_o    = out_bit;
      po_d.mosi_oe_n = ~(en & master);
      po_d.miso_o    = out_bit;
      po_d.miso_oe_n = ~(en & ~master & ~ss_s);
      po_d.ss_o_n    = (st_q == spi_ctl_pkg::ST_IDLE);
      po_d.ss_oe_n   = ~ss_drive;
   end

   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         pins_out     <= `PINS_RESET;
         ss_gpio_free <= 1'b0;
         irq          <= 1'b0;
         prdata       <= 32'h0000_0000;
         pready       <= 1'b0;
         pslverr      <= 1'b0;
      end
      else
      begin
         pins_out     <= po_d;
         ss_gpio_free <= ss_free;
         irq          <= |(stat_q & mask_q);
         pready       <= psel & ~penable;
         pslverr      <= psel & ~penable & ~mapped;
         prdata       <= {24'h000000, rd_mux};
      end
   end

   a_ctl2_reserved: assert property (@(posedge clk) disable iff (rst)
      (ctl2_q & ~`CTL2_MASK) == 8'h00) else $error("ctl2 reserved bit set");
   a_ctl2_write: assert property (@(posedge clk) disable iff (rst)
      wr && hit2 |=> ctl2_q == ($past(pwdata[7:0]) & `CTL2_MASK))
      else $error("ctl2 write lost");
   a_sck_idle: assert property (@(posedge clk) disable iff (rst)
      st_q == spi_ctl_pkg::ST_IDLE && en && master |-> ##1 pins_out.sck_o == $past(clock_polarity))
      else $error("clock idle level wrong");
   a_role_drive: assert property (@(posedge clk) disable iff (rst)
      !master |=> pins_out.sck_oe_n) else $error("slave drives clock");
   a_ss_free: assert property (@(posedge clk) disable iff (rst)
      master && !fault_en |=> ss_gpio_free && pins_out.ss_oe_n)
      else $error("select pin not released");
   a_ss_out: assert property (@(posedge clk) disable iff (rst)
      ss_drive |=> !pins_out.ss_oe_n) else $error("select not driven");
   a_mode_fault: assert property (@(posedge clk) disable iff (rst)
      fault |=> !master ##1 stat_q[`EV_MODF]) else $error("fault not handled");
   a_freeze: assert property (@(posedge clk) disable iff (rst)
      frozen && master |=> $stable(sh_q)) else $error("shifter ran in wait");
   a_phase1_start: assert property (@(posedge clk) disable iff (rst)
      start && clock_phase && !fault |=> sck_q) else $error("phase one first edge late");
   a_slave_load: assert property (@(posedge clk) disable iff (rst)
      ss_fall_slave && !frozen |=> sh_q == $past(tx_q)) else $error("slave word not loaded");
   a_select_low: assert property (@(posedge clk) disable iff (rst)
      ss_drive && st_q != spi_ctl_pkg::ST_IDLE |=> !pins_out.ss_o_n)
      else $error("select not low in frame");
endmodule

// *** hw/spi_ctl_consts.svh ***
// Purpose: offsets, field positions, reset values and timing counts for the serial port
// Assumes: apb word addressing, 50 MHz clock
// Notes: definitions only
`ifndef SPI_CTL_CONSTS_SVH
`define SPI_CTL_CONSTS_SVH
`define OFS_CTL1      12'h000
`define OFS_CTL2      12'h004
`define OFS_STATUS    12'h008
`define OFS_MASK      12'h00c
`define OFS_DATA      12'h010
`define OFS_BAUD      12'h014
`define CTL1_RESET    8'h04
`define CTL2_RESET    8'h00
`define CTL2_MASK     8'h1b
`define BAUD_RESET    8'h0f
`define PINS_RESET    8'hd5
`define B_IRQEN       7
`define B_PORTEN      6
`define B_ROLE        4
`define B_CLOCK_POLARITY        3
`define B_CLOCK_PHASE        2
`define B_SEL_OE      1
`define B_LSBF        0
`define B_FAULT_EN    4
`define B_BIDIR_OE    3
`define B_SWAI        1
`define B_ONE_WIRE    0
`define EV_DONE       0
`define EV_MODF       1
`define EV_W          2
`define BITS_PER_XFER 4'd8
`endif

// *** hw/spi_ctl_pkg.sv ***
// Purpose: shared types of the serial port
// Assumes: consts header holds the numbers
// Notes: none
package spi_ctl_pkg;
   typedef enum logic [1:0]
   {
      ST_IDLE  = 2'b00,
      ST_LEAD  = 2'b01,
      ST_SHIFT = 2'b10,
      ST_TAIL  = 2'b11
   } xfer_st_t;
   typedef struct packed
   {
      logic sck;
      logic mosi;
      logic ss_n;
   } pins_in_t;
   typedef struct packed
   {
      logic sck_o;
      logic sck_oe_n;
      logic mosi_o;
      logic mosi_oe_n;
      logic miso_o;
      logic miso_oe_n;
      logic ss_o_n;
      logic ss_oe_n;
   } pins_out_t;
endpackage

// *** hw/spi_sync2.sv ***
// Purpose: two-flop synchroniser
// Assumes: async level input
// Notes: first flop read only by second
`timescale 1ns/100ps
module spi_sync2
(
   // clock
   input  wire logic clk,
   input  wire logic rst,
   // data
   input  wire logic d,
   output logic      q
);
   logic meta_q;
   always_ff @(posedge clk)
   begin
      meta_q <= rst ? 1'b0 : d;
      q      <= rst ? 1'b0 : meta_q;
   end
endmodule

// *** tb/spi_far_model.sv ***
// Purpose: far-side serial device model, answers one byte per frame
// Assumes: ss_n already folded with the pin's output enable
// Notes: released data line shows the inverse of its last value
`timescale 1ns/100ps
module spi_far_model
(
   // link
   input  wire logic       sck,
   input  wire logic       mosi,
   input  wire logic       ss_n,
   output logic            miso,
   // setup
   input  wire logic       clock_polarity,
   input  wire logic       clock_phase,
   input  wire logic       lsbf,
   input  wire logic [7:0] reply,
   output logic      [7:0] got
);
   int n;
   function automatic int pos(input int k);
      return lsbf ? k : 7 - k;
   endfunction
   initial
   begin
      miso = 1'b0;
      got = 8'h00;
      n = 0;
   end
   always @(negedge ss_n)
   begin
      n = 0;
      miso = reply[pos(0)];
   end
   always @(posedge ss_n)
      miso = ~miso;
   always @(sck)
   begin
      if (ss_n === 1'b0 && n < 8)
      begin
         if ((sck !== clock_polarity) ^ clock_phase)
         begin
            got[pos(n)] = mosi;
            n = n + 1;
         end
         else
            miso = reply[pos(n)];
      end
   end
endmodule

// *** tb/tb_top.sv ***
// Purpose: self-checking bench of the serial port
// Assumes: 50 MHz clk, apb slave with pready handshake
// Notes: far side is spi_far_model
`timescale 1ns/100ps
`include "spi_ctl_consts.svh"
module tb_top;
   typedef struct packed
   {
      logic [11:0] a;
      logic [7:0]  w;
      logic [7:0]  e;
   } row_t;
   logic                   clk;
   logic                   rst;
   logic                   psel;
   logic                   penable;
   logic                   pwrite;
   logic [11:0]            paddr;
   logic [31:0]            pwdata;
   logic [31:0]            prdata;
   logic                   pready;
   logic                   pslverr;
   logic                   cpu_wait;
   logic                   irq;
   spi_ctl_pkg::pins_in_t  pins_in;
   logic                   miso_i;
   spi_ctl_pkg::pins_out_t pins_out;
   logic                   ss_gpio_free;
   logic [2:0]             cfg;
   logic [7:0]             reply;
   logic [7:0]             got;
   logic [7:0]             tx;
   logic [31:0]            r;
   logic                   err;
   logic                   hold_sck;
   logic [7:0]             sm;
   int                     fail_count;
   int                     check_count;
   row_t                   rows [5];
   spi_ctl dut_u
   (
      .clk(clk),
      .rst(rst),
      .psel(psel),
      .penable(penable),
      .pwrite(pwrite),
      .paddr(paddr),
      .pwdata(pwdata),
      .prdata(prdata),
      .pready(pready),
      .pslverr(pslverr),
      .cpu_wait(cpu_wait),
      .irq(irq),
      .pins_in(pins_in),
      .miso_i(miso_i),
      .pins_out(pins_out),
      .ss_gpio_free(ss_gpio_free)
   );
   spi_far_model far_u
   (
      .sck(pins_out.sck_o),
      .mosi(pins_out.mosi_o),
      .ss_n(pins_out.ss_o_n | pins_out.ss_oe_n),
      .miso(miso_i),
      .clock_polarity(cfg[2]),
      .clock_phase(cfg[1]),
      .lsbf(cfg[0]),
      .reply(reply),
      .got(got)
   );
   task automatic wrap_up();
   begin
      $display("checks %0d mismatches %0d", check_count, fail_count);
      if (fail_count == 0 && check_count > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   end
   endtask
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
   begin
      check_count++;
      if (g !== e)
      begin
         fail_count++;
         $display("BAD t=%0t got=%h exp=%h", $time, g, e);
      end
   end
   endtask
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int k;
   begin
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      k = 0;
      do
      begin
         @(posedge clk);
         k++;
      end
      while (pready !== 1'b1 && k < 50);
      r = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (pready !== 1'b1)
      begin
         fail_count++;
         wrap_up();
      end
   end
   endtask
   task automatic wait_done();
      int k;
   begin
      r = 32'h0;
      for (k = 0; k < 300 && r[0] !== 1'b1; k++)
         apb(1'b0, `OFS_STATUS, 32'h0);
      if (r[0] !== 1'b1)
      begin
         fail_count++;
         wrap_up();
      end
   end
   endtask
   initial
   begin
      clk = 1'b0;
      forever
         #10 clk = ~clk;
   end
   initial
   begin
      rst = 1'b1;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h0;
      cpu_wait = 1'b0;
      pins_in = '{sck: 1'b0, mosi: 1'b0, ss_n: 1'b1};
      cfg = 3'h0;
      reply = 8'h00;
      fail_count = 0;
      check_count = 0;
      rows[0] = '{`OFS_CTL2, 8'hff, 8'h1b};
      rows[1] = '{`OFS_CTL2, 8'h00, 8'h00};
      rows[2] = '{`OFS_CTL1, 8'h8f, 8'h8f};
      rows[3] = '{`OFS_BAUD, 8'h03, 8'h03};
      rows[4] = '{`OFS_MASK, 8'h01, 8'h01};
      repeat (5) @(posedge clk);
      rst <= 1'b0;
      apb(1'b0, `OFS_CTL1, 32'h0);
      chk(r, 32'h04);
      apb(1'b0, `OFS_CTL2, 32'h0);
      chk(r, 32'h00);
      apb(1'b0, 12'h018, 32'h0);
      chk({r[30:0], err}, 32'h1);
      foreach (rows[i])
      begin
         apb(1'b1, rows[i].a, {24'h0, rows[i].w});
         apb(1'b0, rows[i].a, 32'h0);
         chk(r, {24'h0, rows[i].e});
      end
      apb(1'b1, `OFS_CTL2, 32'h10);
      for (int c = 0; c < 8; c++)
      begin
         cfg = 3'(c);
         reply = 8'hc3 ^ 8'(c);
         tx = 8'h5a ^ {cfg, cfg, 2'b01};
         cpu_wait <= cfg[0];
         apb(1'b1, `OFS_CTL1, {24'h0, 4'h5, cfg[2:1], 1'b1, cfg[0]});
         repeat (3) @(negedge clk);
         chk(pins_out.sck_o, cfg[2]);
         apb(1'b1, `OFS_DATA, {24'h0, tx});
         wait_done();
         chk(irq, 1'b1);
         apb(1'b0, `OFS_DATA, 32'h0);
         chk(r, {24'h0, reply});
         chk({got, pins_out.sck_oe_n}, {tx, 1'b0});
         apb(1'b1, `OFS_STATUS, 32'h1);
         repeat (2) @(negedge clk);
         chk(irq, 1'b0);
      end
      cpu_wait <= 1'b0;
      apb(1'b1, `OFS_MASK, 32'h0);
      apb(1'b1, `OFS_CTL1, 32'h50);
      pins_in.ss_n <= 1'b0;
      repeat (8) @(posedge clk);
      apb(1'b0, `OFS_STATUS, 32'h0);
      chk({r[1], irq, pins_out.ss_oe_n}, 3'b101);
      apb(1'b1, `OFS_MASK, 32'h2);
      repeat (2) @(negedge clk);
      chk(irq, 1'b1);
      apb(1'b1, `OFS_CTL2, 32'h0);
      pins_in.ss_n <= 1'b1;
      apb(1'b1, `OFS_CTL1, 32'h52);
      repeat (2) @(negedge clk);
      chk({ss_gpio_free, pins_out.ss_oe_n}, 2'b11);
      apb(1'b1, `OFS_CTL1, 32'h42);
      repeat (2) @(negedge clk);
      chk({ss_gpio_free, pins_out.ss_oe_n, pins_out.sck_oe_n}, 3'b011);
      apb(1'b1, `OFS_CTL2, 32'h12);
      apb(1'b1, `OFS_CTL1, 32'h52);
      apb(1'b1, `OFS_STATUS, 32'h3);
      apb(1'b1, `OFS_DATA, 32'ha5);
      repeat (20) @(posedge clk);
      cpu_wait <= 1'b1;
      repeat (4) @(negedge clk);
      hold_sck = pins_out.sck_o;
      repeat (100) @(posedge clk);
      apb(1'b0, `OFS_STATUS, 32'h0);
      chk({r[0], pins_out.sck_o}, {1'b0, hold_sck});
      cpu_wait <= 1'b0;
      wait_done();
      rst <= 1'b1;
      cpu_wait <= 1'b0;
      repeat (5) @(posedge clk);
      rst <= 1'b0;
      apb(1'b0, `OFS_BAUD, 32'h0);
      chk(r, 32'h0f);
      apb(1'b1, `OFS_CTL1, 32'h40);
      apb(1'b1, `OFS_DATA, 32'h3c);
      tx = 8'ha5;
      pins_in.ss_n <= 1'b0;
      for (int i = 7; i >= 0; i--)
      begin
         pins_in.mosi <= tx[i];
         repeat (4) @(posedge clk);
         pins_in.sck <= 1'b1;
         repeat (3) @(posedge clk);
         @(negedge clk);
         sm[i] = pins_out.miso_o;
         @(posedge clk);
         pins_in.sck <= 1'b0;
      end
      repeat (4) @(posedge clk);
      pins_in.ss_n <= 1'b1;
      wait_done();
      apb(1'b0, `OFS_DATA, 32'h0);
      chk(r, 32'ha5);
      chk(sm, 32'h3c);
      wrap_up();
   end
endmodule
